// ### src/ssp_pkg.sv
// constants, encodings and types for the serial memory programming port
package ssp_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ            = 100;
    localparam int unsigned FLASH_WAIT_US      = 4500;
    localparam int unsigned FUSE_WAIT_US       = 4500;
    localparam int unsigned EEPROM_WAIT_US     = 9000;
    localparam int unsigned ERASE_WAIT_US      = 9000;
    localparam int unsigned TIMER_W            = 20;
    localparam logic [19:0] FLASH_WAIT_CYC     = 20'(FLASH_WAIT_US * CLK_MHZ);
    localparam logic [19:0] FUSE_WAIT_CYC      = 20'(FUSE_WAIT_US * CLK_MHZ);
    localparam logic [19:0] EEPROM_WAIT_CYC    = 20'(EEPROM_WAIT_US * CLK_MHZ);
    localparam logic [19:0] ERASE_WAIT_CYC     = 20'(ERASE_WAIT_US * CLK_MHZ);

    // ------------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------------
    localparam int unsigned FLASH_WORDS        = 4096;
    localparam int unsigned PAGE_WORDS         = 32;
    localparam int unsigned EE_BYTES           = 512;
    localparam logic [11:0] SWEEP_LAST         = 12'hFFF;
    localparam logic [7:0]  ERASED_BYTE        = 8'hFF;
    localparam logic [15:0] ERASED_WORD        = 16'hFFFF;
    localparam logic [7:0]  LOCK_RESET         = 8'hFF;
    localparam logic [7:0]  FUSE_LO_RESET      = 8'hFF;
    localparam logic [7:0]  FUSE_HI_RESET      = 8'hFF;

    // ------------------------------------------------------------------
    // instruction encodings
    // ------------------------------------------------------------------
    localparam logic [7:0]  OPC_ENABLE         = 8'hAC;
    localparam logic [7:0]  ENABLE_KEY         = 8'h53;
    localparam logic [7:0]  OPC_RD_PROG        = 8'h20;
    localparam logic [7:0]  OPC_LD_PAGE        = 8'h40;
    localparam logic [7:0]  OPC_WR_PAGE        = 8'h4C;
    localparam logic [7:0]  OPC_RD_EE          = 8'hA0;
    localparam logic [7:0]  OPC_WR_EE          = 8'hC0;
    localparam logic [7:0]  OPC_RD_LOCK        = 8'h58;
    localparam logic [7:0]  OPC_RD_FUSE        = 8'h50;
    localparam logic [7:0]  OPC_RD_SIG         = 8'h30;
    localparam logic [7:0]  OPC_RD_CAL         = 8'h38;
    localparam logic [7:0]  HI_SEL_MASK        = 8'h08;
    localparam logic [2:0]  SUB_ERASE          = 3'b100;
    localparam logic [2:0]  SUB_LOCK           = 3'b111;
    localparam logic [7:0]  SUB_FUSE_LO        = 8'hA0;
    localparam logic [7:0]  SUB_FUSE_HI        = 8'hA8;
    localparam logic [7:0]  SUB_RD_FUSE_HI     = 8'h08;

    // self-timed operation in progress
    typedef enum logic [4:0] {
        OP_IDLE   = 5'b00001,
        OP_FLASH  = 5'b00010,
        OP_EEPROM = 5'b00100,
        OP_ERASE  = 5'b01000,
        OP_FUSE   = 5'b10000
    } op_t;

endpackage

// ### src/link_if.sv
// sampled serial link events passed from the pin sampler to the core
interface link_if;
    logic sck_rise;   // one-cycle pulse on a filtered rising clock edge
    logic sck_fall;   // one-cycle pulse on a filtered falling clock edge
    logic mosi_bit;   // filtered serial data level
    logic session;    // reset pin held low

    modport sampler (output sck_rise, output sck_fall, output mosi_bit, output session);
    modport core    (input sck_rise, input sck_fall, input mosi_bit, input session);
endinterface

// ### src/link_sampler.sv
// synchronises the link pins into the system clock and finds clock edges
module link_sampler (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic sck_pin,
    input  wire logic mosi_pin,
    input  wire logic reset_pin_n,
    link_if.sampler   lnk
);
    // ------------------------------------------------------------------
    // three-stage synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sck_s;
    logic [2:0] mosi_s;
    logic [2:0] rst_s;
    logic       sck_lvl;
    logic       mosi_lvl;
    logic       rst_n_lvl;

    // shift chains, bit 0 is the first stage
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sck_s  <= 3'h0;
            mosi_s <= 3'h0;
            rst_s  <= 3'h7;
        end else begin
            sck_s  <= {sck_s[1:0], sck_pin};
            mosi_s <= {mosi_s[1:0], mosi_pin};
            rst_s  <= {rst_s[1:0], reset_pin_n};
        end
    end

    // a level is taken once the second and third stages agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sck_lvl   <= 1'b0;
            mosi_lvl  <= 1'b0;
            rst_n_lvl <= 1'b1;
        end else begin
            if (sck_s[1] == sck_s[2]) sck_lvl <= sck_s[2];
            if (mosi_s[1] == mosi_s[2]) mosi_lvl <= mosi_s[2];
            if (rst_s[1] == rst_s[2]) rst_n_lvl <= rst_s[2];
        end
    end

    // ------------------------------------------------------------------
    // edge pulses
    // ------------------------------------------------------------------
    // rising and falling edges found
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lnk.sck_rise <= 1'b0;
            lnk.sck_fall <= 1'b0;
        end else begin
            lnk.sck_rise <= (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_lvl;
            lnk.sck_fall <= (sck_s[1] == sck_s[2]) && !sck_s[2] && sck_lvl;
        end
    end

    assign lnk.mosi_bit = mosi_lvl;
    assign lnk.session  = !rst_n_lvl;
endmodule

// ### src/serial_memory_programming_port.sv
// serial programming port: framing, instruction decode, memories and write timer
module serial_memory_programming_port
    import ssp_pkg::*;
#(
    parameter logic [19:0] FLASH_WAIT_CYCLES  = FLASH_WAIT_CYC,
    parameter logic [19:0] FUSE_WAIT_CYCLES   = FUSE_WAIT_CYC,
    parameter logic [19:0] EEPROM_WAIT_CYCLES = EEPROM_WAIT_CYC,
    parameter logic [19:0] ERASE_WAIT_CYCLES  = ERASE_WAIT_CYC,
    parameter logic [7:0]  SIG_BYTE0          = 8'h11, // arbitrary value
    parameter logic [7:0]  SIG_BYTE1          = 8'h22, // arbitrary value
    parameter logic [7:0]  SIG_BYTE2          = 8'h33, // arbitrary value
    parameter logic [7:0]  CAL_BYTE           = 8'h80  // arbitrary value
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic reset_pin_n,
    output logic      miso,
    output logic      miso_oe,
    output logic      busy
);
    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    link_if lnk ();

    link_sampler u_sampler (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .sck_pin     (sck),
        .mosi_pin    (mosi),
        .reset_pin_n (reset_pin_n),
        .lnk         (lnk.sampler)
    );

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [15:0] flash_mem [0:FLASH_WORDS-1];
    logic [7:0]  ee_mem    [0:EE_BYTES-1];
    logic [15:0] pbuf      [0:PAGE_WORDS-1];

    logic        aligned;
    logic        unlocked;
    logic [2:0]  bit_cnt;
    logic [1:0]  byte_idx;
    logic [7:0]  in_sr;
    logic [15:0] window;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  out_sr;
    op_t         op;
    logic [19:0] timer;
    logic [11:0] sweep;
    logic [6:0]  page_sel;
    logic [8:0]  ee_addr;
    logic [7:0]  ee_data;
    logic [7:0]  lock_bits;
    logic [7:0]  fuse_lo;
    logic [7:0]  fuse_hi;

    logic [7:0]  next_byte;
    logic        byte_done;
    logic        exec;
    logic [7:0]  rd_data;
    logic [7:0]  resp;
    logic [11:0] fa;
    logic [8:0]  ea;

    // true when an opcode matches a base code with its high-byte bit ignored
    function automatic logic hsel_match(input logic [7:0] opc, input logic [7:0] base);
        return (opc & ~HI_SEL_MASK) == base;
    endfunction

    assign next_byte = {in_sr[6:0], lnk.mosi_bit};
    assign byte_done = lnk.sck_rise && aligned && (bit_cnt == 3'd7);
    assign exec      = byte_done && (byte_idx == 2'd3) && unlocked && (op == OP_IDLE);
    assign fa        = {b1[3:0], next_byte};
    assign ea        = {b1[0], next_byte};
    assign busy      = (op != OP_IDLE);
    assign miso_oe   = lnk.session;

    // ------------------------------------------------------------------
    // bit framing
    // ------------------------------------------------------------------
    // hunt for the unlock pattern bit by bit
    always_ff @(posedge sys_clk) begin
        if (srst || !lnk.session) begin
            aligned  <= 1'b0;
            bit_cnt  <= 3'd0;
            byte_idx <= 2'd0;
            window   <= 16'h0000;
        end else if (lnk.sck_rise) begin
            window <= {window[14:0], lnk.mosi_bit};
            if (!aligned) begin
                if ({window[14:0], lnk.mosi_bit} == {OPC_ENABLE, ENABLE_KEY}) begin
                    aligned  <= 1'b1;
                    byte_idx <= 2'd2;
                    bit_cnt  <= 3'd0;
                end
            end else begin
                bit_cnt <= bit_cnt + 3'd1;
                if (bit_cnt == 3'd7) byte_idx <= byte_idx + 2'd1;
            end
        end
    end

    // input shifting and byte capture
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            in_sr <= 8'h00;
            b0    <= 8'h00;
            b1    <= 8'h00;
            b2    <= 8'h00;
        end else if (lnk.sck_rise && lnk.session) begin
            in_sr <= next_byte;
            if (!aligned) begin
                b0 <= OPC_ENABLE;
                b1 <= ENABLE_KEY;
            end else if (bit_cnt == 3'd7) begin
                unique case (byte_idx)
                    2'd0: b0 <= next_byte;
                    2'd1: b1 <= next_byte;
                    2'd2: b2 <= next_byte;
                    2'd3: ;
                endcase
            end
        end
    end

    // unlock after the fourth byte of the unlock instruction
    always_ff @(posedge sys_clk) begin
        if (srst || !lnk.session) begin
            unlocked <= 1'b0;
        end else if (byte_done && byte_idx == 2'd3 && b0 == OPC_ENABLE && b1 == ENABLE_KEY) begin
            unlocked <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // read data and output shifting
    // ------------------------------------------------------------------
    // addressed content for read instructions
    always_comb begin
        rd_data = 8'h00;
        if (hsel_match(b0, OPC_RD_PROG)) begin
            if (op == OP_ERASE || (op == OP_FLASH && fa[11:5] == page_sel))
                rd_data = ERASED_BYTE;
            else
                rd_data = b0[3] ? flash_mem[fa][15:8] : flash_mem[fa][7:0];
        end else if (b0 == OPC_RD_EE) begin
            if (op == OP_ERASE || (op == OP_EEPROM && ea == ee_addr))
                rd_data = ERASED_BYTE;
            else
                rd_data = ee_mem[ea];
        end else if (b0 == OPC_RD_LOCK) begin
            rd_data = (b1 == SUB_RD_FUSE_HI) ? fuse_hi : lock_bits;
        end else if (b0 == OPC_RD_FUSE) begin
            rd_data = fuse_lo;
        end else if (b0 == OPC_RD_SIG) begin
            unique case (next_byte[1:0])
                2'd0: rd_data = SIG_BYTE0;
                2'd1: rd_data = SIG_BYTE1;
                2'd2: rd_data = SIG_BYTE2;
                2'd3: rd_data = 8'h00;
            endcase
        end else if (b0 == OPC_RD_CAL) begin
            rd_data = CAL_BYTE;
        end
    end

    // echo the previous byte; read data fills the fourth slot
    always_comb begin
        if (byte_idx == 2'd2 && unlocked) resp = rd_data;
        else if (byte_idx == 2'd3) resp = 8'h00;
        else resp = next_byte;
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !lnk.session) begin
            out_sr <= 8'h00;
            miso   <= 1'b0;
        end else if (lnk.sck_rise && !aligned &&
                     {window[14:0], lnk.mosi_bit} == {OPC_ENABLE, ENABLE_KEY}) begin
            out_sr <= ENABLE_KEY; // key echo in third slot
        end else if (byte_done) begin
            out_sr <= resp;
        end else if (lnk.sck_fall) begin
            miso   <= out_sr[7];
            out_sr <= {out_sr[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // self-timed operations
    // ------------------------------------------------------------------
    // busy held for the full write time
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            op       <= OP_IDLE;
            timer    <= 20'd0;
            page_sel <= 7'd0;
            ee_addr  <= 9'd0;
            ee_data  <= 8'h00;
        end else if (exec) begin
            if (b0 == OPC_WR_PAGE) begin
                // page from upper seven address bits
                op       <= OP_FLASH;
                timer    <= FLASH_WAIT_CYCLES;
                page_sel <= {b1[3:0], b2[7:5]};
            end else if (b0 == OPC_WR_EE) begin
                op      <= OP_EEPROM;
                timer   <= EEPROM_WAIT_CYCLES;
                ee_addr <= {b1[0], b2};
                ee_data <= next_byte;
            end else if (b0 == OPC_ENABLE && b1[7:5] == SUB_ERASE) begin
                op    <= OP_ERASE;
                timer <= ERASE_WAIT_CYCLES;
            end else if (b0 == OPC_ENABLE &&
                         (b1[7:5] == SUB_LOCK || b1 == SUB_FUSE_LO || b1 == SUB_FUSE_HI)) begin
                op    <= OP_FUSE;
                timer <= FUSE_WAIT_CYCLES;
            end
        end else if (op != OP_IDLE) begin
            timer <= timer - 20'd1;
            if (timer <= 20'd1) op <= OP_IDLE;
        end
    end

    // sweep index used by page commit and chip erase
    always_ff @(posedge sys_clk) begin
        if (srst || exec) begin
            sweep <= 12'd0;
        end else if ((op == OP_FLASH || op == OP_ERASE) && sweep != SWEEP_LAST) begin
            sweep <= sweep + 12'd1;
        end
    end

    // commit page; erase to all ones
    always_ff @(posedge sys_clk) begin
        if (op == OP_ERASE) begin
            flash_mem[sweep] <= ERASED_WORD;
        end else if (op == OP_FLASH && sweep < 12'(PAGE_WORDS)) begin
            flash_mem[{page_sel, sweep[4:0]}] <= pbuf[sweep[4:0]];
        end
    end

    // auto-erase then write at end of the timed cycle
    always_ff @(posedge sys_clk) begin
        if (op == OP_ERASE && sweep < 12'(EE_BYTES)) begin
            ee_mem[sweep[8:0]] <= ERASED_BYTE;
        end else if (op == OP_EEPROM && timer == 20'd1) begin
            ee_mem[ee_addr] <= ee_data;
        end
    end

    // page buffer byte loads, emptied once committed
    always_ff @(posedge sys_clk) begin
        if (exec && hsel_match(b0, OPC_LD_PAGE)) begin
            if (b0[3]) pbuf[b2[4:0]][15:8] <= next_byte;
            else pbuf[b2[4:0]][7:0] <= next_byte;
        end else if (op == OP_FLASH && sweep < 12'(PAGE_WORDS)) begin
            pbuf[sweep[4:0]] <= ERASED_WORD;
        end
    end

    // lock and fuse bytes; erase clears lock bits
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lock_bits <= LOCK_RESET;
            fuse_lo   <= FUSE_LO_RESET;
            fuse_hi   <= FUSE_HI_RESET;
        end else if (exec && b0 == OPC_ENABLE) begin
            if (b1[7:5] == SUB_ERASE) lock_bits <= LOCK_RESET;
            else if (b1[7:5] == SUB_LOCK) lock_bits <= lock_bits & next_byte;
            else if (b1 == SUB_FUSE_LO) fuse_lo <= next_byte;
            else if (b1 == SUB_FUSE_HI) fuse_hi <= next_byte;
        end
    end
endmodule

// ### sim/serial_memory_programming_port_assertions.sv
// pin-level checks on the serial programming port
module ssp_port_checker #(
    parameter logic [19:0] FLASH_WAIT_CYCLES  = 20'h258,
    parameter logic [19:0] FUSE_WAIT_CYCLES   = 20'h258,
    parameter logic [19:0] EEPROM_WAIT_CYCLES = 20'h258,
    parameter logic [19:0] ERASE_WAIT_CYCLES  = 20'h1068
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sck,
    input wire logic mosi,
    input wire logic reset_pin_n,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        sck_q;
    logic [3:0]  fall_age;
    logic [3:0]  rise_age;
    logic [19:0] busy_len;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // previous sampled link clock level
    always_ff @(posedge sys_clk) begin
        sck_q <= sck;
    end

    // cycles since the last falling link clock edge
    always_ff @(posedge sys_clk) begin
        if (srst || (sck_q && !sck)) fall_age <= 4'h0;
        else if (fall_age != 4'hF) fall_age <= fall_age + 4'h1;
    end

    // cycles since the last rising link clock edge
    always_ff @(posedge sys_clk) begin
        if (srst || (!sck_q && sck)) rise_age <= 4'h0;
        else if (rise_age != 4'hF) rise_age <= rise_age + 4'h1;
    end

    // length of the current busy stretch
    always_ff @(posedge sys_clk) begin
        if (srst || !busy) busy_len <= 20'h0;
        else busy_len <= busy_len + 20'h1;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    // session drives output
    oe_open_a: assert property (!reset_pin_n [*6] |-> miso_oe)
        else $error("output enable low during session");
    oe_close_a: assert property (reset_pin_n [*6] |-> !miso_oe)
        else $error("output enable high outside session");
    miso_edge_a: assert property (($changed(miso) && miso_oe && $past(miso_oe))
        |-> fall_age inside {[4'h2:4'h7]})
        else $error("serial output changed away from a falling edge");
    busy_len_a: assert property ($fell(busy) |-> busy_len inside
        {[FLASH_WAIT_CYCLES:FLASH_WAIT_CYCLES + 20'h1],
         [FUSE_WAIT_CYCLES:FUSE_WAIT_CYCLES + 20'h1],
         [EEPROM_WAIT_CYCLES:EEPROM_WAIT_CYCLES + 20'h1],
         [ERASE_WAIT_CYCLES:ERASE_WAIT_CYCLES + 20'h1]})
        else $error("busy stretch has a wrong length");
    busy_cause_a: assert property ($rose(busy) |-> rise_age inside {[4'h2:4'h8]})
        else $error("busy rose away from a rising edge");
    busy_sess_a: assert property ($rose(busy) |-> miso_oe)
        else $error("busy rose outside a session");
    busy_hold_a: assert property ($rose(busy) |-> busy [*8])
        else $error("busy dropped too early");
    busy_gap_a: assert property ($fell(busy) |-> !busy [*8])
        else $error("busy restarted without a new instruction");

    cover property ($fell(busy) && busy_len > 20'h3E8);
    cover property ($rose(busy));
    cover property ($fell(miso_oe));
endmodule

bind serial_memory_programming_port ssp_port_checker #(
    .FLASH_WAIT_CYCLES  (FLASH_WAIT_CYCLES),
    .FUSE_WAIT_CYCLES   (FUSE_WAIT_CYCLES),
    .EEPROM_WAIT_CYCLES (EEPROM_WAIT_CYCLES),
    .ERASE_WAIT_CYCLES  (ERASE_WAIT_CYCLES)
) chk_u (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .sck         (sck),
    .mosi        (mosi),
    .reset_pin_n (reset_pin_n),
    .miso        (miso),
    .miso_oe     (miso_oe),
    .busy        (busy)
);

// ### sim/isp_programmer.sv
// external programmer model: reset pin and serial link master
module isp_programmer (
    input  wire logic sys_clk,
    input  wire logic miso,
    output logic      sck,
    output logic      mosi,
    output logic      reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sck         = 1'b0;
        mosi        = 1'b0;
        reset_pin_n = 1'b0;
    end

    task automatic half();
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) begin
            mosi = tx[i];
            half();
            sck = 1'b1;
            half();
            rx[i] = miso; // late in the high phase, well after the fall update
            sck = 1'b0;
        end
        mosi = ~tx[0]; // released line shows the inverse of its last bit
    endtask

    task automatic set_reset(input logic lvl);
        reset_pin_n = lvl;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule

// ### sim/serial_memory_programming_port_tb_top.sv
// self-checking bench for the serial programming port
module serial_memory_programming_port_tb_top;
    import ssp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // write delays scaled down to keep the run short
    localparam logic [19:0] WAIT_SHORT = 20'h258;  // 600 cycles
    localparam logic [19:0] WAIT_ERASE = 20'h1068; // 4200 cycles
    localparam logic [7:0]  SIG0       = 8'h11;    // arbitrary value
    localparam logic [7:0]  SIG1       = 8'h22;    // arbitrary value
    localparam logic [7:0]  SIG2       = 8'h33;    // arbitrary value
    localparam logic [7:0]  CAL        = 8'h80;    // arbitrary value

    logic        sys_clk    = 1'b0;
    logic        srst       = 1'b1;
    logic        sck;
    logic        mosi;
    logic        reset_pin_n;
    logic        miso;
    logic        miso_oe;
    logic        busy;
    logic [31:0] rx;
    int          fail_count = 0;
    int          n_compared = 0;

    always #5 sys_clk = ~sys_clk;

    serial_memory_programming_port #(
        .FLASH_WAIT_CYCLES  (WAIT_SHORT),
        .FUSE_WAIT_CYCLES   (WAIT_SHORT),
        .EEPROM_WAIT_CYCLES (WAIT_SHORT),
        .ERASE_WAIT_CYCLES  (WAIT_ERASE),
        .SIG_BYTE0          (SIG0),
        .SIG_BYTE1          (SIG1),
        .SIG_BYTE2          (SIG2),
        .CAL_BYTE           (CAL)
    ) dut_u (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .sck         (sck),
        .mosi        (mosi),
        .reset_pin_n (reset_pin_n),
        .miso        (miso),
        .miso_oe     (miso_oe),
        .busy        (busy)
    );

    isp_programmer prog_u (
        .sys_clk     (sys_clk),
        .miso        (miso),
        .sck         (sck),
        .mosi        (mosi),
        .reset_pin_n (reset_pin_n)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one instruction, then let busy settle
    task automatic cmd(input logic [31:0] tx);
        prog_u.xfer(tx, rx);
        repeat (6) @(negedge sys_clk);
    endtask

    // poll busy, no other instruction meanwhile
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 6000) begin
            @(negedge sys_clk);
            n++;
        end
        cmp_bit(busy, 1'b0);
        repeat (8) @(negedge sys_clk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_refused();
        repeat (40) @(negedge sys_clk); // shortened start wait
        cmd({OPC_WR_EE, 24'h01_235A});
        cmp_bit(busy, 1'b0);
    endtask

    task automatic t_unlock();
        cmd({OPC_ENABLE, ENABLE_KEY, 16'h0000});
        cmp_byte(rx[15:8], ENABLE_KEY);
    endtask

    task automatic t_erase();
        cmd({OPC_ENABLE, 24'h80_0000});
        cmp_bit(busy, 1'b1);
        cmd({OPC_RD_EE, 24'h01_FF00});
        cmp_byte(rx[7:0], ERASED_BYTE);
        wait_idle();
        cmd({OPC_RD_PROG | HI_SEL_MASK, 24'h0F_FF00});
        cmp_byte(rx[7:0], ERASED_BYTE);
        cmd({OPC_RD_EE, 24'h01_FF00});
        cmp_byte(rx[7:0], ERASED_BYTE);
    endtask

    task automatic t_page();
        cmd({OPC_LD_PAGE, 24'h00_05A5});
        cmd({OPC_LD_PAGE | HI_SEL_MASK, 24'h00_053C});
        cmd({OPC_WR_PAGE, 24'h00_2000});
        cmp_bit(busy, 1'b1);
        cmd({OPC_RD_PROG, 24'h00_2500});
        cmp_byte(rx[7:0], ERASED_BYTE);
        wait_idle();
        cmd({OPC_RD_PROG, 24'h00_2500});
        cmp_byte(rx[7:0], 8'hA5);
        cmd({OPC_RD_PROG | HI_SEL_MASK, 24'h00_2500});
        cmp_byte(rx[7:0], 8'h3C);
        cmd({OPC_RD_PROG, 24'h00_0500});
        cmp_byte(rx[7:0], ERASED_BYTE);
        cmd({OPC_RD_PROG, 24'h00_4600});
        cmp_byte(rx[7:0], ERASED_BYTE);
    endtask

    task automatic t_eeprom();
        logic [7:0] d [2] = '{8'h5A, 8'h81};
        // second value rewrites over the first without a chip erase
        for (int i = 0; i < 2; i++) begin
            cmd({OPC_WR_EE, 16'h01_23, d[i]});
            cmd({OPC_RD_EE, 24'h01_2300});
            cmp_byte(rx[7:0], ERASED_BYTE);
            wait_idle();
            cmd({OPC_RD_EE, 24'h01_2300});
            cmp_byte(rx[7:0], d[i]);
        end
    endtask

    task automatic t_ids();
        logic [31:0] q [7] = '{32'h3000_0000, 32'h3000_0100, 32'h3000_0200,
            32'h3800_0000, 32'h5800_0000, 32'h5000_0000, 32'h5808_0000};
        logic [7:0]  e [7] = '{SIG0, SIG1, SIG2, CAL, LOCK_RESET, FUSE_LO_RESET,
            FUSE_HI_RESET};
        for (int i = 0; i < 7; i++) begin
            cmd(q[i]);
            cmp_byte(rx[7:0], e[i]);
            cmp_byte(rx[23:16], q[i][31:24]);
        end
    endtask

    // lock and fuse writes, read back through their own read codes
    task automatic t_fuses();
        cmd({OPC_ENABLE, SUB_FUSE_LO, 16'h005C});
        cmp_bit(busy, 1'b1);
        wait_idle();
        cmd({OPC_ENABLE, SUB_FUSE_HI, 16'h00C9});
        wait_idle();
        cmd({OPC_ENABLE, SUB_LOCK, 21'h0000FC});
        wait_idle();
        cmd({OPC_RD_FUSE, 24'h00_0000});
        cmp_byte(rx[7:0], 8'h5C);
        cmd({OPC_RD_LOCK, 24'h08_0000});
        cmp_byte(rx[7:0], 8'hC9);
        cmd({OPC_RD_LOCK, 24'h00_0000});
        cmp_byte(rx[7:0], 8'hFC);
    endtask

    task automatic t_session();
        prog_u.set_reset(1'b1);
        cmp_bit(miso_oe, 1'b0);
        prog_u.set_reset(1'b0);
        cmp_bit(miso_oe, 1'b1);
        cmd({OPC_WR_EE, 24'h01_2300});
        cmp_bit(busy, 1'b0);
        cmd({OPC_ENABLE, ENABLE_KEY, 16'hFFFF});
        cmp_byte(rx[15:8], ENABLE_KEY);
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        srst = 1'b0;
        t_refused();
        t_unlock();
        t_erase();
        t_page();
        t_eeprom();
        t_ids();
        t_fuses();
        t_session();
        give_verdict();
    end

    // cut a hang short well after the expected run length
    initial begin
        repeat (40000) @(posedge sys_clk);
        fail_count++;
        give_verdict();
    end
endmodule
